/* include/mdf_regs_map.svh */
// Offsets, field positions, reset values and timing counts of the fault and PWM config registers
`ifndef MDF_REGS_MAP_SVH
`define MDF_REGS_MAP_SVH
`define MDF_ADDR_W 6
`define MDF_DATA_W 16
`define MDF_OFS_FAULT_CTRL 6'h13
`define MDF_OFS_FAULT_CLEAR 6'h17
`define MDF_OFS_PWM_CTRL 6'h20
`define MDF_RST_FAULT_CTRL 16'h1010
`define MDF_RST_FAULT_CLEAR 16'h0000
`define MDF_RST_PWM_CTRL 16'h0020
`define MDF_MASK_FAULT_CTRL 16'h3535
`define MDF_MASK_PWM_CTRL 16'h7FFF
`define MDF_BIT_PARITY 15
`define MDF_BIT_OVERVOLT 8
`define MDF_BIT_DEG_HI 5
`define MDF_BIT_DEG_LO 4
`define MDF_BIT_RETRY 2
`define MDF_BIT_TRIP 0
`define MDF_BIT_CLEAR 0
`define MDF_BIT_RATE_HI 7
`define MDF_BIT_RATE_LO 6
`define MDF_BIT_RECIRC 5
`define MDF_BIT_AAR 3
`define MDF_BIT_ASR 2
`define MDF_BIT_MODE_HI 1
`define MDF_BIT_MODE_LO 0
`define MDF_CORE_CLK_MHZ 20
`define MDF_DEG0_NS 600
`define MDF_DEG1_NS 1250
`define MDF_DEG2_NS 1600
`define MDF_DEG3_NS 2000
`define MDF_RETRY_SHORT_US 5000
`define MDF_RETRY_LONG_US 500000
`define MDF_DEG_CYC(ns) (((ns) * `MDF_CORE_CLK_MHZ + 999) / 1000)
`define MDF_RETRY_SHORT_CYC (`MDF_RETRY_SHORT_US * `MDF_CORE_CLK_MHZ)
`define MDF_RETRY_LONG_CYC (`MDF_RETRY_LONG_US * `MDF_CORE_CLK_MHZ)
`endif

/* include/mdf_pkg.sv */
// Types shared by the fault and PWM configuration register bank
`default_nettype none
package mdf_pkg;
   typedef struct packed
   {
      logic write;
      logic [5:0] addr;
      logic [15:0] wdata;
   } mdf_link_req_t;
   typedef struct packed
   {
      logic overvoltage_level_select;
      logic [1:0] overcurrent_deglitch_select;
      logic overcurrent_retry_time;
      logic overcurrent_trip_level;
      logic [1:0] full_duty_pwm_rate;
      logic current_limit_recirculation;
      logic negative_current_lowside_off_enable;
      logic active_demag_enable;
      logic three_input_pwm;
   } mdf_cfg_t;
endpackage
`default_nettype wire

/* hw/mdf_regs.sv */
// Fault threshold, fault clear and PWM control registers with a link-clock access port
//
// Contract
// - Bit 15 of every register reads parity when parity is on, else zero.
// - Bit 8 of fault control picks supply overvoltage level: 0 high, 1 low.
// - Bits 5-4 pick overcurrent deglitch 0.6, 1.25, 1.6 or 2 us; reset 1.
// - Bit 2 picks overcurrent retry wait: 0 is 5 ms, 1 is 500 ms.
// - Bit 0 of fault control picks trip current: 0 is 4.5 A, 1 is 2.5 A.
// - Writing 1 to clear bit 0 clears latched faults; bit self-clears, reads zero.
// - Bits 7-6 of PWM control pick full-duty rate 20, 40, 10 kHz or none.
// - Bit 5 picks recirculation: 0 through transistors, 1 through diodes; reset 1.
// - Bit 3 set switches low side off once phase current goes negative.
// - Bit 2 of PWM control enables active demagnetization; reset 0.
// - Bits 1-0 select six-input for codes 0,1 and three-input for 2,3.
// - Overcurrent response code 0 latches the fault, code 1 retries automatically.
// - Parity enable 0 disables parity, 1 makes bit 15 carry parity.
`timescale 1ns/1ps
`default_nettype none
`include "mdf_regs_map.svh"
module mdf_regs
   import mdf_pkg::*;
#(
   parameter int unsigned RETRY_SHORT_CYCLES = `MDF_RETRY_SHORT_CYC,
   parameter int unsigned RETRY_LONG_CYCLES = `MDF_RETRY_LONG_CYC
)
(
   // Core clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET,
   // Link side register access
   input wire logic LINK_CLK,
   input wire logic LINK_REQ,
   input wire logic LINK_WRITE,
   input wire logic [5:0] LINK_ADDR,
   input wire logic [15:0] LINK_WDATA,
   output logic LINK_ACK,
   output var logic [15:0] LINK_RDATA,
   // Settings from neighbouring registers
   input wire logic SPI_PARITY_ENABLE,
   input wire logic [1:0] OVERCURRENT_RESPONSE,
   // Phase current sign from the analog front end
   input wire logic CURRENT_NEGATIVE,
   // Configuration outputs
   output var mdf_cfg_t CFG,
   output var logic [5:0] DEGLITCH_CYCLES,
   output var logic [31:0] RETRY_CYCLES,
   output var logic FAULT_CLEAR,
   output var logic OCP_LATCHED,
   output var logic OCP_AUTO_RETRY,
   output var logic LOWSIDE_FORCE_OFF
);

   localparam logic [5:0] DEG0_CYC = 6'(`MDF_DEG_CYC(`MDF_DEG0_NS));
   localparam logic [5:0] DEG1_CYC = 6'(`MDF_DEG_CYC(`MDF_DEG1_NS));
   localparam logic [5:0] DEG2_CYC = 6'(`MDF_DEG_CYC(`MDF_DEG2_NS));
   localparam logic [5:0] DEG3_CYC = 6'(`MDF_DEG_CYC(`MDF_DEG3_NS));

   function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic logic [5:0] deg_cycles(input logic [1:0] code);
      case (code)
         2'h0: deg_cycles = DEG0_CYC;
         2'h1: deg_cycles = DEG1_CYC;
         2'h2: deg_cycles = DEG2_CYC;
         default: deg_cycles = DEG3_CYC;
      endcase
   endfunction

   // Link domain: hold the request and flag it by a toggle
   mdf_link_req_t lreq_q;
   logic lreq_tgl_q;
   logic [2:0] lack_sync_q;
   logic [15:0] lrdata_q;
   logic lack_edge;
   logic ack_tgl_q;
   logic [15:0] rd_q;
   logic lack_q;

   // Requester must wait for the ack before the next request
   always_ff @(posedge LINK_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         lreq_q <= '0;
         lreq_tgl_q <= 1'b0;
      end
      else if (LINK_REQ)
      begin
         lreq_q <= '{write: LINK_WRITE, addr: LINK_ADDR, wdata: LINK_WDATA};
         lreq_tgl_q <= ~lreq_tgl_q;
      end
   end

   always_ff @(posedge LINK_CLK or posedge RESET)
   begin
      if (RESET)
         lack_sync_q <= 3'b000;
      else
         lack_sync_q <= {lack_sync_q[1:0], ack_tgl_q};
   end

   assign lack_edge = lack_sync_q[2] ^ lack_sync_q[1];

   // Read word is loaded as the ack toggles and held still in the core until the next request, so it is safe to sample
   // Ack is registered with the read word so both stand in the same link cycle
   always_ff @(posedge LINK_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         lrdata_q <= 16'h0000;
         lack_q <= 1'b0;
      end
      else
      begin
         lack_q <= lack_edge;
         if (lack_edge)
            lrdata_q <= rd_q;
      end
   end

   assign LINK_ACK = lack_q;
   assign LINK_RDATA = lrdata_q;

   // Core domain
   logic [2:0] creq_sync_q;
   logic [1:0] cneg_sync_q;
   logic [15:0] fault_q, fault_d, pwm_q, pwm_d, rd_d, rd_raw;
   logic take, wr, hit_fault, hit_clear, hit_pwm, par_bit, clear_d;

   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         creq_sync_q <= 3'b000;
         cneg_sync_q <= 2'b00;
      end
      else
      begin
         creq_sync_q <= {creq_sync_q[1:0], lreq_tgl_q};
         cneg_sync_q <= {cneg_sync_q[0], CURRENT_NEGATIVE};
      end
   end

   assign take = creq_sync_q[2] ^ creq_sync_q[1];
   assign wr = take & lreq_q.write;
   assign hit_fault = hit(lreq_q.addr, `MDF_OFS_FAULT_CTRL);
   assign hit_clear = hit(lreq_q.addr, `MDF_OFS_FAULT_CLEAR);
   assign hit_pwm = hit(lreq_q.addr, `MDF_OFS_PWM_CTRL);

   assign fault_d = (wr & hit_fault) ? (lreq_q.wdata & `MDF_MASK_FAULT_CTRL) : fault_q;
   assign pwm_d = (wr & hit_pwm) ? (lreq_q.wdata & `MDF_MASK_PWM_CTRL) : pwm_q;
   assign clear_d = wr & hit_clear & lreq_q.wdata[`MDF_BIT_CLEAR];

   // clear register reads zero; unmapped reads zero
   assign rd_raw = hit_fault ? fault_q : (hit_pwm ? pwm_q : 16'h0000);
   assign par_bit = SPI_PARITY_ENABLE & (^rd_raw[14:0]);
   assign rd_d = take ? {par_bit, rd_raw[14:0]} : rd_q;

   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         fault_q <= `MDF_RST_FAULT_CTRL;
         pwm_q <= `MDF_RST_PWM_CTRL;
         rd_q <= 16'h0000;
         ack_tgl_q <= 1'b0;
         FAULT_CLEAR <= 1'b0;
      end
      else
      begin
         fault_q <= fault_d;
         pwm_q <= pwm_d;
         rd_q <= rd_d;
         ack_tgl_q <= ack_tgl_q ^ take;
         FAULT_CLEAR <= clear_d;
      end
   end

   assign CFG.overvoltage_level_select = fault_q[`MDF_BIT_OVERVOLT];
   assign CFG.overcurrent_trip_level = fault_q[`MDF_BIT_TRIP];
   assign CFG.overcurrent_deglitch_select = fault_q[`MDF_BIT_DEG_HI:`MDF_BIT_DEG_LO];
   assign CFG.overcurrent_retry_time = fault_q[`MDF_BIT_RETRY];
   assign CFG.full_duty_pwm_rate = pwm_q[`MDF_BIT_RATE_HI:`MDF_BIT_RATE_LO];
   assign CFG.current_limit_recirculation = pwm_q[`MDF_BIT_RECIRC];
   assign CFG.negative_current_lowside_off_enable = pwm_q[`MDF_BIT_AAR];
   assign CFG.active_demag_enable = pwm_q[`MDF_BIT_ASR];
   // three-input when high code bit set
   assign CFG.three_input_pwm = pwm_q[`MDF_BIT_MODE_HI];

   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         DEGLITCH_CYCLES <= DEG1_CYC;
         RETRY_CYCLES <= 32'h0000_0000;
         OCP_LATCHED <= 1'b0;
         OCP_AUTO_RETRY <= 1'b0;
         LOWSIDE_FORCE_OFF <= 1'b0;
      end
      else
      begin
         DEGLITCH_CYCLES <= deg_cycles(fault_q[`MDF_BIT_DEG_HI:`MDF_BIT_DEG_LO]);
         RETRY_CYCLES <= fault_q[`MDF_BIT_RETRY] ? RETRY_LONG_CYCLES : RETRY_SHORT_CYCLES;
         OCP_LATCHED <= (OVERCURRENT_RESPONSE == 2'h0);
         OCP_AUTO_RETRY <= (OVERCURRENT_RESPONSE == 2'h1);
         // low side off on negative current
         LOWSIDE_FORCE_OFF <= pwm_q[`MDF_BIT_AAR] & cneg_sync_q[1];
      end
   end

   // Checks
   a_clear_pulse_once: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (wr && hit_clear && lreq_q.wdata[0]) |=> FAULT_CLEAR ##1 !FAULT_CLEAR)
      else $error("fault clear pulse wrong");
   a_clear_needs_write: assert property (@(posedge CORE_CLK) disable iff (RESET)
      $rose(FAULT_CLEAR) |-> $past(take) && $past(hit_clear))
      else $error("fault clear without write");
   a_parity_readback: assert property (@(posedge CORE_CLK) disable iff (RESET)
      take |=> rd_q[15] == ($past(SPI_PARITY_ENABLE) & (^rd_q[14:0])))
      else $error("parity bit wrong");
   a_parity_off_zero: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (take && !SPI_PARITY_ENABLE) |=> !rd_q[15])
      else $error("bit 15 set with parity off");
   a_reserved_fault_zero: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (fault_q & ~`MDF_MASK_FAULT_CTRL) == 16'h0000 && !pwm_q[15])
      else $error("reserved bit set");
   a_ovp_write: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (wr && hit_fault) |=> CFG.overvoltage_level_select == $past(lreq_q.wdata[8]))
      else $error("overvoltage select not written");
   a_deglitch_count: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (fault_q[5:4] == 2'h1) [*2] |-> DEGLITCH_CYCLES == 6'h19)
      else $error("deglitch count wrong");
   a_retry_count: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (!fault_q[2]) [*2] |-> RETRY_CYCLES == RETRY_SHORT_CYCLES)
      else $error("retry count wrong");
   a_trip_write: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (wr && hit_fault) |=> CFG.overcurrent_trip_level == $past(lreq_q.wdata[0]))
      else $error("trip level not written");
   a_mode_write: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (wr && hit_pwm) |=> CFG.three_input_pwm == $past(lreq_q.wdata[1]))
      else $error("input scheme not written");
   a_lowside_off: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (!pwm_q[3]) |=> !LOWSIDE_FORCE_OFF)
      else $error("low side forced off while disabled");
   a_response_code: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (OVERCURRENT_RESPONSE == 2'h1) |=> OCP_AUTO_RETRY && !OCP_LATCHED)
      else $error("overcurrent response decode wrong");
   a_link_ack_bound: assert property (@(posedge LINK_CLK) disable iff (RESET)
      LINK_REQ |-> ##[2:12] LINK_ACK)
      else $error("link ack missing");
   a_link_ack_single: assert property (@(posedge LINK_CLK) disable iff (RESET)
      LINK_ACK |=> !LINK_ACK)
      else $error("link ack longer than one cycle");
   a_deglitch_short: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (fault_q[5:4] == 2'h0) [*2] |-> DEGLITCH_CYCLES == 6'h0C)
      else $error("short deglitch count wrong");
   a_deglitch_mid: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (fault_q[5:4] == 2'h2) [*2] |-> DEGLITCH_CYCLES == 6'h20)
      else $error("middle deglitch count wrong");
   a_deglitch_long: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (fault_q[5:4] == 2'h3) [*2] |-> DEGLITCH_CYCLES == 6'h28)
      else $error("long deglitch count wrong");
   a_retry_long: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (fault_q[2]) [*2] |-> RETRY_CYCLES == RETRY_LONG_CYCLES)
      else $error("long retry count wrong");
   a_rate_write: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (wr && hit_pwm) |=> CFG.full_duty_pwm_rate == $past(lreq_q.wdata[7:6]))
      else $error("full duty rate not written");
   a_recirc_write: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (wr && hit_pwm) |=> CFG.current_limit_recirculation == $past(lreq_q.wdata[5]))
      else $error("recirculation not written");
   a_demag_write: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (wr && hit_pwm) |=> CFG.active_demag_enable == $past(lreq_q.wdata[2]))
      else $error("demag enable not written");
   a_lowside_follow: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (pwm_q[3] && cneg_sync_q[1]) |=> LOWSIDE_FORCE_OFF)
      else $error("low side not forced off");
   a_response_latched: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (OVERCURRENT_RESPONSE == 2'h0) |=> OCP_LATCHED && !OCP_AUTO_RETRY)
      else $error("latched response decode wrong");
   a_clear_reads_zero: assert property (@(posedge CORE_CLK) disable iff (RESET)
      (take && hit_clear) |=> rd_q == 16'h0000)
      else $error("fault clear register read nonzero");
   a_fault_write_guard: assert property (@(posedge CORE_CLK) disable iff (RESET)
      !(wr && hit_fault) |=> fault_q == $past(fault_q))
      else $error("fault control changed without write");
   c_clear_issued: cover property (@(posedge CORE_CLK) disable iff (RESET) FAULT_CLEAR);
   c_parity_read: cover property (@(posedge CORE_CLK) disable iff (RESET)
      take && SPI_PARITY_ENABLE && !lreq_q.write);
   c_pwm_write: cover property (@(posedge CORE_CLK) disable iff (RESET) wr && hit_pwm);
   c_link_ack: cover property (@(posedge LINK_CLK) disable iff (RESET) LINK_ACK);
   c_auto_retry: cover property (@(posedge CORE_CLK) disable iff (RESET) OCP_AUTO_RETRY);

endmodule
`default_nettype wire

/* test/mdf_link_host.sv */
// Link-side controller model issuing one register access at a time
`timescale 1ns/1ps
`default_nettype none
module mdf_link_host
(
   // Link clock
   input wire logic link_clk,
   // Request
   output logic req,
   output logic write,
   output logic [5:0] addr,
   output logic [15:0] wdata,
   // Answer
   input wire logic ack,
   input wire logic [15:0] rdata
);
   initial
   begin
      req = 1'b0;
      write = 1'b0;
      addr = 6'h00;
      wdata = 16'h0000;
   end
   // Accesses that never saw an acknowledge
   int timeouts = 0;
   // Fields hold until the acknowledge; a missing answer leaves rd unknown and is counted
   task automatic access(input logic w, input logic [5:0] a, input logic [15:0] d,
      output logic [15:0] rd);
      int n;
      logic seen;
      rd = 16'hxxxx;
      n = 0;
      seen = 1'b0;
      @(negedge link_clk);
      req = 1'b1;
      write = w;
      addr = a;
      wdata = d;
      @(negedge link_clk);
      req = 1'b0;
      while (n < 8 && !seen)
      begin
         @(negedge link_clk);
         n++;
         if (ack === 1'b1)
         begin
            rd = rdata;
            seen = 1'b1;
         end
      end
      if (!seen)
         timeouts++;
      @(negedge link_clk);
      // Released data is scrambled so a stale value cannot pass
      wdata = ~d;
   endtask
endmodule
`default_nettype wire

/* test/mdf_regs_tb.sv */
// Self-checking bench for the fault and PWM configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "mdf_regs_map.svh"
module mdf_regs_tb
   import mdf_pkg::*;
;
   logic core_clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst = 1'b1;
   logic par_en = 1'b0;
   logic [1:0] resp = 2'h0;
   logic neg = 1'b0;
   logic req, wr, ack, clr, latched, auto, off;
   logic [5:0] addr, deg;
   logic [15:0] wdata, rdata;
   logic [31:0] retry;
   mdf_cfg_t cfg;
   logic [5:0] tbl [4] = '{6'h0C, 6'h19, 6'h20, 6'h28};
   int bad_count = 0;
   int n_compared = 0;
   int pulses = 0;
   int cycles = 0;
   always #25 core_clk = ~core_clk;
   always #62.5 link_clk = ~link_clk;
   mdf_regs #(.RETRY_SHORT_CYCLES(8), .RETRY_LONG_CYCLES(16)) mdf_regs_i (
      .CORE_CLK(core_clk), .RESET(rst), .LINK_CLK(link_clk), .LINK_REQ(req),
      .LINK_WRITE(wr), .LINK_ADDR(addr), .LINK_WDATA(wdata), .LINK_ACK(ack),
      .LINK_RDATA(rdata), .SPI_PARITY_ENABLE(par_en), .OVERCURRENT_RESPONSE(resp),
      .CURRENT_NEGATIVE(neg), .CFG(cfg), .DEGLITCH_CYCLES(deg), .RETRY_CYCLES(retry),
      .FAULT_CLEAR(clr), .OCP_LATCHED(latched), .OCP_AUTO_RETRY(auto),
      .LOWSIDE_FORCE_OFF(off));
   mdf_link_host mdf_link_host_i (.link_clk(link_clk), .req(req), .write(wr),
      .addr(addr), .wdata(wdata), .ack(ack), .rdata(rdata));
   task automatic report_and_stop;
      bad_count += mdf_link_host_i.timeouts;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Pulse width counter doubles as the hang guard
   always @(posedge core_clk)
   begin
      cycles++;
      if (clr === 1'b1)
         pulses++;
      if (cycles == 8000)
      begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
      logic [15:0] v;
      mdf_link_host_i.access(1'b1, a, d, v);
   endtask
   task automatic rd_reg(input logic [5:0] a, output logic [15:0] v);
      mdf_link_host_i.access(1'b0, a, 16'h0000, v);
   endtask
   task automatic cw(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic t_reset;
      logic [15:0] v;
      rd_reg(`MDF_OFS_FAULT_CTRL, v);
      check(v, 16'h1010); // reset value
      rd_reg(`MDF_OFS_FAULT_CLEAR, v);
      check(v, 16'h0000); // reset value
      rd_reg(`MDF_OFS_PWM_CTRL, v);
      check(v, 16'h0020); // reset value
      rd_reg(6'h3F, v);
      check(v, 16'h0000); // unmapped read
      check(retry, 32'h0000_0008); // short retry
   endtask
   task automatic t_fault_parity;
      logic [15:0] v;
      wr_reg(`MDF_OFS_FAULT_CTRL, 16'hFFFF);
      rd_reg(`MDF_OFS_FAULT_CTRL, v);
      check(v, 16'h3535); // reserved bits
      check({cfg.overvoltage_level_select, cfg.overcurrent_deglitch_select,
         cfg.overcurrent_retry_time, cfg.overcurrent_trip_level}, 5'h1F);
      check(retry, 32'h0000_0010); // long retry
      cw(1);
      par_en = 1'b1;
      wr_reg(`MDF_OFS_PWM_CTRL, 16'h7FFF);
      rd_reg(`MDF_OFS_PWM_CTRL, v);
      check(v, 16'hFFFF); // odd word parity
      rd_reg(`MDF_OFS_FAULT_CTRL, v);
      check(v, 16'h3535); // even word parity
      cw(1);
      par_en = 1'b0;
      rd_reg(`MDF_OFS_PWM_CTRL, v);
      check(v, 16'h7FFF); // parity off
   endtask
   task automatic t_fields;
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(`MDF_OFS_FAULT_CTRL, {10'h000, i[1:0], 4'h0});
         wr_reg(`MDF_OFS_PWM_CTRL, {8'h00, i[1:0], i[0], 1'b0, i[1], i[0], i[1:0]});
         cw(3);
         check(deg, tbl[i]); // deglitch count
         check({cfg.full_duty_pwm_rate, cfg.current_limit_recirculation,
            cfg.negative_current_lowside_off_enable, cfg.active_demag_enable,
            cfg.three_input_pwm}, {i[1:0], i[0], i[1], i[0], i[1]});
         check(cfg.active_demag_enable, i[0]); // demag enable
      end
   endtask
   task automatic t_clear;
      logic [15:0] v;
      int base;
      base = pulses;
      wr_reg(`MDF_OFS_FAULT_CLEAR, 16'h0001);
      cw(4);
      check(pulses - base, 1); // one clear pulse
      wr_reg(`MDF_OFS_FAULT_CLEAR, 16'hFFFE);
      rd_reg(`MDF_OFS_FAULT_CLEAR, v);
      check(v, 16'h0000); // reads zero
      check(pulses - base, 1); // no pulse without bit 0
   endtask
   task automatic t_pins;
      cw(1);
      for (int i = 0; i < 4; i++)
      begin
         resp = i[1:0];
         cw(3);
         check({latched, auto}, {i == 0, i == 1}); // response code
      end
      wr_reg(`MDF_OFS_PWM_CTRL, 16'h0008);
      cw(1);
      neg = 1'b1;
      cw(4);
      check(off, 1'b1); // low side off
      neg = 1'b0;
      cw(4);
      check(off, 1'b0); // current positive
      neg = 1'b1;
      wr_reg(`MDF_OFS_PWM_CTRL, 16'h0000);
      cw(4);
      check(off, 1'b0); // feature disabled
   endtask
   // Second reset in mid-run must bring every field back to its reset value
   task automatic t_rst_again;
      logic [15:0] v;
      wr_reg(`MDF_OFS_FAULT_CTRL, 16'h0131);
      wr_reg(`MDF_OFS_PWM_CTRL, 16'h00CF);
      cw(1);
      check(cfg, 32'h0000_0777); // fields written
      rst = 1'b1;
      cw(2);
      check(cfg, 32'h0000_0108); // fields in reset
      check(deg, 6'h19); // deglitch in reset
      cw(3);
      rst = 1'b0;
      rd_reg(`MDF_OFS_FAULT_CTRL, v);
      check(v, 16'h1010); // value after reset
      rd_reg(`MDF_OFS_PWM_CTRL, v);
      check(v, 16'h0020); // value after reset
   endtask
   initial
   begin
      cw(4);
      rst = 1'b0;
      t_reset();
      t_fault_parity();
      t_fields();
      t_clear();
      t_pins();
      t_rst_again();
      report_and_stop();
   end
endmodule
`default_nettype wire
